// ===== hdl/dscw_control.sv
// drive state control word interpreter: control word register and operating-state machine
// assumes the control word write strobe comes from logic on clk_i; dc bus ok, fault
// and reaction-done inputs are synchronous device signals
`timescale 1ns/10ps
module dscw_control
  import dscw_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cw_write_i,
  input wire logic [15:0] cw_wdata_i,
  input wire logic dc_bus_ok_i,
  input wire logic fault_i,
  input wire logic fault_reaction_done_i,
  input wire logic init_done_i,
  output logic [15:0] drive_control_word_o,
  output logic [3:0] op_state_o,
  output logic halt_o,
  output logic [2:0] mode_bits_o,
  output logic mode_bit9_o,
  output logic power_stage_on_o
);
  logic [15:0] cw_q;
  logic [15:0] cw_d;
  logic fr_prev_q;
  dscw_state_t st_q;
  dscw_state_t st_d;
  logic [3:0] code_q;
  logic [3:0] code_d;
  logic halt_q;
  logic [2:0] mode_q;
  logic mode9_q;
  logic pwr_q;

  // new word used in the same cycle it is written
  assign cw_d = cw_write_i ? cw_wdata_i : cw_q;
  wire logic b_so = cw_d[DSCW_BIT_SWITCH_ON];
  wire logic b_ev = cw_d[DSCW_BIT_ENABLE_VOLTAGE];
  wire logic b_qs = cw_d[DSCW_BIT_QUICK_STOP];
  wire logic b_eo = cw_d[DSCW_BIT_ENABLE_OPERATION];
  wire logic b_fr = cw_d[DSCW_BIT_FAULT_RESET];
  // reserved bits are stored as written but never decoded
  wire logic fr_rise = b_fr & ~fr_prev_q;
  wire logic cmd_shutdown = ~b_fr & b_qs & b_ev & ~b_so;
  wire logic cmd_on = ~b_fr & b_qs & b_ev & b_so;
  wire logic cmd_disv = ~b_fr & ~b_ev;
  wire logic cmd_qs = ~b_fr & b_ev & ~b_qs;
  // a fault overrides any word; the fault states themselves are left only by their own events
  wire logic fault_enter = fault_i && (st_q != DSCW_FAULT) && (st_q != DSCW_FAULT_REACT);
  // power stage follows the next state so it switches on the same edge as the state code
  wire logic pwr_d = (st_d == DSCW_OP_ENABLED) || (st_d == DSCW_QSTOP) || (st_d == DSCW_FAULT_REACT);

  // each state lists only the words or input events that leave it; anything else falls through and holds
  always_comb begin
    st_d = st_q;
    case (st_q)
      DSCW_NOT_READY: begin
        if (init_done_i) begin
          st_d = DSCW_SW_ON_DIS;
        end
      end
      DSCW_SW_ON_DIS: begin
        // low bus voltage blocks T2; the held word retries every cycle
        if (cmd_shutdown && dc_bus_ok_i) begin
          st_d = DSCW_READY;
        end
      end
      DSCW_READY: begin
        if (cmd_on && !b_eo) begin
          st_d = DSCW_SWITCHED_ON;
        end else if (cmd_disv || cmd_qs) begin
          st_d = DSCW_SW_ON_DIS;
        end
      end
      DSCW_SWITCHED_ON: begin
        // enable operation only from switched on or quick stop; a word with both bits set in ready holds there
        if (cmd_on && b_eo) begin
          st_d = DSCW_OP_ENABLED;
        end else if (cmd_shutdown) begin
          st_d = DSCW_READY;
        end else if (cmd_disv || cmd_qs) begin
          st_d = DSCW_SW_ON_DIS;
        end
      end
      DSCW_OP_ENABLED: begin
        if (cmd_on && !b_eo) begin
          st_d = DSCW_SWITCHED_ON;
        end else if (cmd_shutdown) begin
          st_d = DSCW_READY;
        end else if (cmd_disv) begin
          st_d = DSCW_SW_ON_DIS;
        end else if (cmd_qs) begin
          st_d = DSCW_QSTOP;
        end
      end
      DSCW_QSTOP: begin
        if (cmd_disv) begin
          st_d = DSCW_SW_ON_DIS;
        end else if (cmd_on && b_eo) begin
          st_d = DSCW_OP_ENABLED;
        end
      end
      DSCW_FAULT_REACT: begin
        if (fault_reaction_done_i) begin
          st_d = DSCW_FAULT;
        end
      end
      DSCW_FAULT: begin
        if (fr_rise) begin
          st_d = DSCW_SW_ON_DIS;
        end
      end
      default: begin
        st_d = DSCW_NOT_READY;
      end
    endcase
    if (fault_enter) begin
      st_d = DSCW_FAULT_REACT;
    end
  end

  always_comb begin
    case (st_d)
      DSCW_NOT_READY: code_d = DSCW_ST_NOT_READY;
      DSCW_SW_ON_DIS: code_d = DSCW_ST_SWITCH_ON_DISABLED;
      DSCW_READY: code_d = DSCW_ST_READY;
      DSCW_SWITCHED_ON: code_d = DSCW_ST_SWITCHED_ON;
      DSCW_OP_ENABLED: code_d = DSCW_ST_OP_ENABLED;
      DSCW_QSTOP: code_d = DSCW_ST_QUICK_STOP;
      DSCW_FAULT_REACT: code_d = DSCW_ST_FAULT_REACTION;
      DSCW_FAULT: code_d = DSCW_ST_FAULT;
      default: code_d = DSCW_ST_NOT_READY;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      cw_q <= DSCW_CONTROL_RESET;
    end else begin
      cw_q <= cw_d;
    end
  end

  // edge reference for fault reset is the stored bit, so a held 1 never re-triggers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      fr_prev_q <= 1'b0;
    end else begin
      fr_prev_q <= b_fr;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= DSCW_NOT_READY;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      code_q <= DSCW_ST_NOT_READY;
    end else begin
      code_q <= code_d;
    end
  end

  // mode and halt outputs follow the stored word
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      halt_q <= 1'b0;
    end else begin
      halt_q <= cw_d[DSCW_BIT_HALT];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode_q <= 3'h0;
    end else begin
      mode_q <= cw_d[DSCW_BIT_MODE_HI:DSCW_BIT_MODE_LO];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mode9_q <= 1'b0;
    end else begin
      mode9_q <= cw_d[DSCW_BIT_MODE9];
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_q <= 1'b0;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  assign drive_control_word_o = cw_q;
  assign op_state_o = code_q;
  assign halt_o = halt_q;
  assign mode_bits_o = mode_q;
  assign mode_bit9_o = mode9_q;
  assign power_stage_on_o = pwr_q;
endmodule

// ===== hdl/dscw_pkg.sv
// drive state control word package: field positions, reset values, state codes
// assumes a single device clock domain
package dscw_pkg;
  localparam int DSCW_WIDTH = 16;
  localparam int DSCW_BIT_SWITCH_ON = 0;
  localparam int DSCW_BIT_ENABLE_VOLTAGE = 1;
  localparam int DSCW_BIT_QUICK_STOP = 2;
  localparam int DSCW_BIT_ENABLE_OPERATION = 3;
  localparam int DSCW_BIT_MODE_LO = 4;
  localparam int DSCW_BIT_MODE_HI = 6;
  localparam int DSCW_BIT_FAULT_RESET = 7;
  localparam int DSCW_BIT_HALT = 8;
  localparam int DSCW_BIT_MODE9 = 9;
  localparam logic [15:0] DSCW_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] DSCW_RESERVED_MASK = 16'hFC00;
  // numeric state codes as shown to the status logic
  localparam logic [3:0] DSCW_ST_NOT_READY = 4'h2;
  localparam logic [3:0] DSCW_ST_SWITCH_ON_DISABLED = 4'h3;
  localparam logic [3:0] DSCW_ST_READY = 4'h4;
  localparam logic [3:0] DSCW_ST_SWITCHED_ON = 4'h5;
  localparam logic [3:0] DSCW_ST_OP_ENABLED = 4'h6;
  localparam logic [3:0] DSCW_ST_QUICK_STOP = 4'h7;
  localparam logic [3:0] DSCW_ST_FAULT_REACTION = 4'h8;
  localparam logic [3:0] DSCW_ST_FAULT = 4'h9;
  typedef enum {
    DSCW_NOT_READY, DSCW_SW_ON_DIS, DSCW_READY, DSCW_SWITCHED_ON,
    DSCW_OP_ENABLED, DSCW_QSTOP, DSCW_FAULT_REACT, DSCW_FAULT
  } dscw_state_t;
endpackage

// ===== sim/dscw_checker.sv
// port checker for the control word interpreter
// assumes one clock domain, reset_i asynchronous active high
`timescale 1ns/10ps
module dscw_checker (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cw_write_i,
  input wire logic [15:0] cw_wdata_i,
  input wire logic dc_bus_ok_i,
  input wire logic fault_i,
  input wire logic [15:0] drive_control_word_o,
  input wire logic [3:0] op_state_o,
  input wire logic halt_o,
  input wire logic [2:0] mode_bits_o,
  input wire logic mode_bit9_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire logic wr = cw_write_i && !fault_i && !cw_wdata_i[7];
  wire logic [3:0] s = op_state_o;
  word_store_a: assert property (cw_write_i |=> drive_control_word_o == $past(cw_wdata_i))
    else $error("readback wrong");
  halt_req_a: assert property (cw_write_i |=> halt_o == $past(cw_wdata_i[8]))
    else $error("halt wrong");
  mode_pass_a: assert property (cw_write_i |=>
    {mode_bit9_o, mode_bits_o} == {$past(cw_wdata_i[9]), $past(cw_wdata_i[6:4])})
    else $error("mode bits wrong");
  go_ready_a: assert property (s == 4'h3 && dc_bus_ok_i && wr && cw_wdata_i[2:0] == 3'h6 |=> s == 4'h4)
    else $error("no ready");
  bus_low_a: assert property (s == 4'h3 && !dc_bus_ok_i |=> s != 4'h4)
    else $error("ready with bus low");
  switch_on_a: assert property (s == 4'h4 && wr && cw_wdata_i[3:0] == 4'h7 |=> s == 4'h5)
    else $error("no switch on");
  enable_op_a: assert property (s == 4'h5 && wr && cw_wdata_i[3:0] == 4'hF |=> s == 4'h6)
    else $error("no enable");
  volt_off_a: assert property (s inside {[4'h4:4'h7]} && wr && !cw_wdata_i[1] |=> s == 4'h3)
    else $error("no disable voltage");
  fault_clear_a: assert property (s == 4'h9 && !fault_i && !drive_control_word_o[7] && cw_write_i && cw_wdata_i[7]
    |=> s == 4'h3)
    else $error("no fault reset");
endmodule

// ===== sim/dscw_master.sv
// fieldbus master model: writes whole control words with a one-cycle strobe
// assumes the interpreter samples the word on the rising edge of clk_i
`timescale 1ns/10ps
module dscw_master (
  input wire logic clk_i,
  output logic cw_write_o,
  output logic [15:0] cw_wdata_o
);
  initial begin
    cw_write_o = 1'h0;
    cw_wdata_o = 16'h0000;
  end
  // whole words only, reserved bits zero while the strobe is high
  task automatic send(input logic [15:0] w);
    @(posedge clk_i);
    #1 cw_write_o = 1'h1;
    cw_wdata_o = w & 16'h03FF;
    @(posedge clk_i);
    #1 cw_write_o = 1'h0;
    cw_wdata_o = ~cw_wdata_o; // stale data must not look like a valid word
  endtask
endmodule

// ===== sim/tb_top.sv
// bench top: master model writes words, states and outputs checked against a table
// assumes a 200 MHz clock and the master model in dscw_master.sv
`timescale 1ns/10ps
module tb_top;
  import dscw_pkg::*;
  logic clk_i = 0, reset_i = 1, dc_bus_ok_i = 1, fault_i = 0, done_i = 0, init_i = 0, cw_write, halt_o, bit9_o, pwr_o;
  logic [15:0] cw_wdata, word_o;
  logic [3:0] st_o;
  logic [2:0] mode_o;
  logic [31:0] rnd = 67;
  int n_mismatch = 0, check_count = 0;
  // {expected state, word}; random halt and mode bits are added on top
  logic [19:0] seq[$] = '{20'h50007, 20'h6000F, 20'h7000B, 20'h6000F, 20'h50007, 20'h40006, 20'h30002,
    20'h40006, 20'h50007, 20'h6000F, 20'h30004, 20'h30007};
  always #2.5 clk_i = ~clk_i;
  dscw_master m (.clk_i, .cw_write_o(cw_write), .cw_wdata_o(cw_wdata));
  dscw_control dut (.clk_i, .reset_i, .cw_write_i(cw_write), .cw_wdata_i(cw_wdata), .dc_bus_ok_i, .fault_i,
    .fault_reaction_done_i(done_i), .init_done_i(init_i), .drive_control_word_o(word_o), .op_state_o(st_o),
    .halt_o, .mode_bits_o(mode_o), .mode_bit9_o(bit9_o), .power_stage_on_o(pwr_o));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic step(input logic [15:0] base, input logic [3:0] exp);
    logic [15:0] w;
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    w = base | (rnd[15:0] & 16'h0370);
    m.send(w);
    chk(16'(st_o), 16'(exp));
    chk(word_o, w);
    chk(16'(halt_o), 16'(w[8]));
    chk(16'({bit9_o, mode_o}), 16'({w[9], w[6:4]}));
    chk(16'(pwr_o), 16'(exp inside {4'h6, 4'h7}));
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    #1 reset_i = 0;
    chk(16'(st_o), 16'h0002);
    chk(word_o, 16'h0000);
    init_i = 1;
    dc_bus_ok_i = 0;
    repeat (2) @(posedge clk_i);
    #1 chk(16'(st_o), 16'h0003);
    step(16'h0006, 4'h3);
    dc_bus_ok_i = 1;
    @(posedge clk_i);
    #1 chk(16'(st_o), 16'h0004);
    foreach (seq[i]) step(seq[i][15:0], seq[i][19:16]);
    fault_i = 1;
    @(posedge clk_i);
    #1 fault_i = 0;
    chk(16'(st_o), 16'h0008);
    chk(16'(pwr_o), 16'h0001);
    done_i = 1;
    @(posedge clk_i);
    #1 chk(16'(st_o), 16'h0009);
    step(16'h0000, 4'h9);
    step(16'h008F, 4'h3);
    summarize();
  end
  // generous bound: the whole sequence takes well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
endmodule
bind dscw_control dscw_checker chk_u (.clk_i, .reset_i, .cw_write_i, .cw_wdata_i, .dc_bus_ok_i, .fault_i,
  .drive_control_word_o, .op_state_o, .halt_o, .mode_bits_o, .mode_bit9_o);
